// *** usc_params.svh ***
// constants of the user interrupt priority scheduler
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH
`define USC_NSRC      24
`define USC_IDW       5
`define USC_AW        8
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define USC_CFG_OFF   8'h00
`define USC_AUTO_OFF  8'h04
`define USC_START_OFF 8'h08
`define USC_ENA_OFF   8'h0c
`define USC_PEND_OFF  8'h10
`define USC_LOST_OFF  8'h14
`define USC_STAT_OFF  8'h18
`define USC_ISTS_OFF  8'h1c
`define USC_IMSK_OFF  8'h20
// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define USC_CFG_RST   24'h000000
`define USC_AUTO_RST  24'h000000
`define USC_ENA_RST   24'hffffff
`define USC_IMSK_RST  3'h0
`define USC_IS_DISP   0
`define USC_IS_LOST   1
`define USC_IS_FAULT  2
`define USC_STAT_FLT  31
`endif

// *** usc_pkg.sv ***
// types shared by the user interrupt priority scheduler
package usc_pkg;
    // instructions issued by the program execution engine
    typedef enum logic [1:0] {
        usc_op_disable,
        usc_op_enable,
        usc_op_flush,
        usc_op_clear
    } usc_op_type;
    // one instruction with its selection mask
    typedef struct packed {
        logic        valid;
        usc_op_type  op;
        logic [23:0] mask;
    } usc_instr_type;
    // a program unit reference towards the engine
    typedef struct packed {
        logic       valid;
        logic [4:0] id;
    } usc_unit_type;
    // scheduler mode
    typedef enum logic {
        usc_run,
        usc_fault
    } usc_mode_type;
endpackage : usc_pkg

// *** usc_scheduler.sv ***
// user interrupt priority scheduler with apb register access
//
// The APB slave port and the placing of the registers were left to the implementer.
`include "usc_params.svh"
module usc_scheduler import usc_pkg::*; (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [23:1]   src_event,       // source pins, async
    input  wire logic          user_fault,      // fault pulse, pclk
    input  wire logic          fault_user_class,
    input  wire usc_instr_type instr,
    input  wire logic          handler_done,
    output usc_unit_type       dispatch,
    output usc_unit_type       resume,
    output logic               resume_main,
    output logic               fault_mode,
    output logic               irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [23:1]  sync1_reg;      // first synchroniser stage
    logic [23:1]  sync2_reg;      // second synchroniser stage
    logic [23:1]  last_reg;       // previous level, edge detect
    logic [23:0]  cfg_reg;        // configured sources
    logic [23:0]  auto_reg;       // start on boot setting
    logic [23:0]  started_reg;    // explicitly started
    logic [23:0]  ena_reg;        // enable selection
    logic [23:0]  pending_reg;    // pending flags
    logic [23:0]  lost_reg;       // lost flags
    logic [23:0]  active_reg;     // handlers in progress
    logic         ret_reg;        // a handler other than the fault routine just completed
    usc_mode_type mode_reg;       // run or fault
    logic [2:0]   ists_reg;       // sticky interrupt status
    logic [2:0]   imsk_reg;       // interrupt mask
    logic [23:0]  new_req;        // request edges this cycle
    logic [23:0]  eligible;       // dispatchable now
    logic [23:0]  clr_pend;       // pending clears this cycle
    logic [23:0]  lost_set;       // lost flag sets this cycle
    usc_unit_type cand;           // best eligible request
    usc_unit_type act;            // running handler
    logic         go;             // dispatch this cycle
    logic         fault_done;     // fault handler completed
    logic         apb_setup;
    logic         apb_wr;
    logic         apb_rd;
    logic         ists_rc;        // read of status clears it
    logic [2:0]   ists_set;

    // lowest index wins, which is the priority order itself
    function automatic usc_unit_type first_set(input logic [23:0] v);
        usc_unit_type r;
        r = '0;
        for (int i = `USC_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r.valid = 1'b1;
                r.id    = 5'(i);
            end
        end
        return r;
    endfunction : first_set

    // ------------------------------------------------------------
    // source capture
    // ------------------------------------------------------------
    // pins cross into pclk through two flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            last_reg  <= '0;
        end else begin
            sync1_reg <= src_event;
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    // bit 0 is the fault routine, only user-class faults count
    assign new_req = {sync2_reg & ~last_reg,
                      user_fault & fault_user_class};

    // ------------------------------------------------------------
    // selection and dispatch
    // ------------------------------------------------------------
    always_comb begin
        // fault routine needs no start and cannot be disabled
        eligible    = pending_reg & cfg_reg & ena_reg
                    & (auto_reg | started_reg);
        eligible[0] = pending_reg[0] & cfg_reg[0];
    end

    assign cand = first_set(eligible);
    assign act  = first_set(active_reg);
    assign fault_done = handler_done & act.valid & (act.id == 5'h00);
    // strictly higher priority only; done cycles settle first
    assign go = cand.valid & (mode_reg == usc_run) & ~handler_done
              & (~act.valid || cand.id < act.id);

    // handlers in progress form a nest ordered by priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_reg <= '0;
        end else if (fault_done) begin
            active_reg <= '0;
        end else if (go) begin
            active_reg[cand.id] <= 1'b1;
        end else if (handler_done && act.valid) begin
            active_reg[act.id] <= 1'b0;
        end
    end

    // mode: fault is left only by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= usc_run;
        end else begin
            unique case (mode_reg)
                usc_run: begin
                    if (fault_done) begin
                        mode_reg <= usc_fault;
                    end
                end
                usc_fault: begin
                    mode_reg <= usc_fault;
                end
            endcase
        end
    end

    // unit sequencing towards the engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_reg     <= 1'b0;
            dispatch    <= '0;
            resume      <= '0;
            resume_main <= 1'b0;
            fault_mode  <= 1'b0;
        end else begin
            ret_reg        <= handler_done & ~fault_done;
            dispatch.valid <= go;
            dispatch.id    <= cand.id;
            // nothing more urgent: go back where we stopped
            resume.valid   <= ret_reg & ~go & act.valid;
            resume.id      <= act.id;
            resume_main    <= ret_reg & ~go & ~act.valid;
            fault_mode     <= (mode_reg == usc_fault) | fault_done;
        end
    end

    // ------------------------------------------------------------
    // pending and lost flags
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < `USC_NSRC; i++) begin : g_src
            // mask bit 0 is reserved for the instructions
            assign clr_pend[i] = (go && cand.id == 5'(i))
                || (instr.valid && instr.op == usc_op_flush
                    && instr.mask[i] && i != 0);
            assign lost_set[i] = new_req[i] & cfg_reg[i]
                               & pending_reg[i] & ~clr_pend[i];
            // a new request wins over any clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pending_reg[i] <= 1'b0;
                end else if (new_req[i] && cfg_reg[i]) begin
                    pending_reg[i] <= 1'b1;
                end else if (clr_pend[i]) begin
                    pending_reg[i] <= 1'b0;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lost_reg[i] <= 1'b0;
                end else if (lost_set[i]) begin
                    lost_reg[i] <= 1'b1;
                end else if (instr.valid && instr.op == usc_op_clear
                             && instr.mask[i] && i != 0) begin
                    lost_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // protection zones from disable and enable instructions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ena_reg <= `USC_ENA_RST;
        end else if (instr.valid && instr.op == usc_op_disable) begin
            ena_reg <= ena_reg & ~{instr.mask[23:1], 1'b0};
        end else if (instr.valid && instr.op == usc_op_enable) begin
            ena_reg <= ena_reg | {instr.mask[23:1], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // apb slave, wait state free access
    // ------------------------------------------------------------
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pready & pwrite & ~pslverr;
    assign apb_rd    = psel & penable & pready & ~pwrite;
    assign ists_rc   = apb_rd & (paddr == `USC_ISTS_OFF);

    // read data is staged in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (apb_setup) begin
                unique case (paddr)
                    `USC_CFG_OFF:   prdata <= {8'h00, cfg_reg};
                    `USC_AUTO_OFF:  prdata <= {8'h00, auto_reg};
                    `USC_START_OFF: prdata <= {8'h00, started_reg};
                    `USC_ENA_OFF:   prdata <= {8'h00, ena_reg};
                    `USC_PEND_OFF:  prdata <= {8'h00, pending_reg};
                    `USC_LOST_OFF:  prdata <= {8'h00, lost_reg};
                    `USC_STAT_OFF:  prdata <= {fault_mode, 7'h00,
                                               active_reg};
                    `USC_ISTS_OFF:  prdata <= {29'h0, ists_reg};
                    `USC_IMSK_OFF:  prdata <= {29'h0, imsk_reg};
                    // unmapped: error and zero data
                    default:        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // software registers; start bits only accumulate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg     <= `USC_CFG_RST;
            auto_reg    <= `USC_AUTO_RST;
            started_reg <= '0;
            imsk_reg    <= `USC_IMSK_RST;
        end else if (apb_wr) begin
            if (paddr == `USC_CFG_OFF) begin
                cfg_reg <= pwdata[23:0];
            end
            if (paddr == `USC_AUTO_OFF) begin
                auto_reg <= pwdata[23:0];
            end
            if (paddr == `USC_START_OFF) begin
                started_reg <= started_reg | pwdata[23:0];
            end
            if (paddr == `USC_IMSK_OFF) begin
                imsk_reg <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, read clears, a new event wins
    // ------------------------------------------------------------
    always_comb begin
        ists_set                = '0;
        ists_set[`USC_IS_DISP]  = go;
        ists_set[`USC_IS_LOST]  = |lost_set;
        ists_set[`USC_IS_FAULT] = fault_done;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_reg <= '0;
            irq      <= 1'b0;
        end else begin
            // clear only the bits the read returned, so late sets survive
            ists_reg <= (ists_reg & ~(ists_rc ? prdata[2:0] : 3'h0)) | ists_set;
            // one cycle behind status, kept registered
            irq      <= |(ists_reg & imsk_reg);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_disp_eligible: assert property (@(posedge pclk)
        disable iff (!presetn)
        dispatch.valid |-> (($past(eligible) >> dispatch.id) & 24'h1) != 24'h0)
        else $error("dispatch of an ineligible source");

    chk_disp_best: assert property (@(posedge pclk)
        disable iff (!presetn)
        dispatch.valid |-> ($past(eligible) & ((24'h1 << dispatch.id)
            - 24'h1)) == 24'h0)
        else $error("dispatch skipped a higher priority request");

    chk_lower_waits: assert property (@(posedge pclk)
        disable iff (!presetn)
        (act.valid && cand.valid && cand.id > act.id)
        |=> !dispatch.valid)
        else $error("lower priority pre-empted a handler");

    chk_preempt_now: assert property (@(posedge pclk)
        disable iff (!presetn)
        (act.valid && cand.valid && cand.id < act.id
         && !handler_done && mode_reg == usc_run)
        |=> dispatch.valid && dispatch.id == $past(cand.id))
        else $error("higher priority not serviced at once");

    chk_fault_stop: assert property (@(posedge pclk)
        disable iff (!presetn)
        fault_done |=> fault_mode && !dispatch.valid
        ##1 (fault_mode && !dispatch.valid)[*3])
        else $error("program continued after fault handler");

    chk_resume_once: assert property (@(posedge pclk)
        disable iff (!presetn)
        (handler_done && !fault_done) ##1 !go
        |=> (resume.valid ^ resume_main))
        else $error("no resume after handler completion");

    chk_disable_zone: assert property (@(posedge pclk)
        disable iff (!presetn)
        (instr.valid && instr.op == usc_op_disable)
        |=> (ena_reg[23:1] & $past(instr.mask[23:1])) == 23'h0
            ##1 !(dispatch.valid && dispatch.id != 5'h00
                  && (($past(instr.mask, 2) >> dispatch.id) & 24'h1)
                     != 24'h0))
        else $error("disabled source not held off");

    chk_flush_drop: assert property (@(posedge pclk)
        disable iff (!presetn)
        (instr.valid && instr.op == usc_op_flush && new_req == 24'h0)
        |=> (pending_reg[23:1] & $past(instr.mask[23:1])) == 23'h0)
        else $error("flush left a selected request pending");

    chk_lost_cause: assert property (@(posedge pclk)
        disable iff (!presetn)
        (lost_reg & ~$past(lost_reg)) != 24'h0
        |-> $past(new_req & pending_reg) != 24'h0)
        else $error("lost flag set without a repeat request");

    chk_fault_class: assert property (@(posedge pclk)
        disable iff (!presetn)
        (user_fault && !fault_user_class && !pending_reg[0])
        |=> !pending_reg[0])
        else $error("non-user fault queued the fault routine");
endmodule : usc_scheduler

// *** usc_engine_model.sv ***
// program engine model that finishes handlers on command
module usc_engine_model import usc_pkg::*; (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire usc_unit_type dispatch,
    input  wire logic         finish,
    output logic              handler_done
);
    logic [4:0] depth_reg;  // handlers started and not yet finished

    // -----------------------------------------------------------
    // unit nesting
    // -----------------------------------------------------------
    // each dispatch suspends the unit in hand, each done returns to it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_reg <= 5'h00;
        end else begin
            depth_reg <= depth_reg + 5'(dispatch.valid) - 5'(handler_done);
        end
    end

    // done is a single pulse and only while a handler runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            handler_done <= 1'b0;
        end else begin
            handler_done <= finish && (depth_reg != 5'h00) && !handler_done;
        end
    end
endmodule : usc_engine_model

// *** user_interrupt_priority_scheduler_bench.sv ***
// self-checking bench of the user interrupt priority scheduler
`include "usc_params.svh"
module user_interrupt_priority_scheduler_bench import usc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic          pclk = 1'b0;      // 25 MHz
    logic          presetn = 1'b0;   // active low reset
    logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, r;
    logic          pready, pslverr, e;
    logic [23:1]   src_event = '0;   // source pins
    logic          user_fault = 1'b0, fault_user_class = 1'b0;
    usc_instr_type instr = '0;
    logic          handler_done, finish = 1'b0;
    usc_unit_type  dispatch, resume;
    logic          resume_main, fault_mode, irq;
    logic [6:0]    evq[$];           // engine events in arrival order
    int            n_errors = 0, checks_done = 0;
    localparam logic [23:0] M = 24'h088822; // ev0 cnt0 ev4 timed0 plug0
    always #20 pclk = ~pclk;

    usc_scheduler u_usc_scheduler (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_event(src_event), .user_fault(user_fault),
        .fault_user_class(fault_user_class), .instr(instr),
        .handler_done(handler_done), .dispatch(dispatch), .resume(resume),
        .resume_main(resume_main), .fault_mode(fault_mode), .irq(irq));
    usc_engine_model u_usc_engine_model (.pclk(pclk), .presetn(presetn),
        .dispatch(dispatch), .finish(finish), .handler_done(handler_done));

    // log dispatch (00,id), resume (01,id) and main resume (40)
    always @(posedge pclk) begin
        if (dispatch.valid === 1'b1) evq.push_back({2'b00, dispatch.id});
        if (resume.valid === 1'b1) evq.push_back({2'b01, resume.id});
        if (resume_main === 1'b1) evq.push_back(7'h40);
    end

    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; only the watchdog ends the wait for pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic op(input usc_op_type o, input logic [23:0] m);
        instr <= '{1'b1, o, m};
        @(posedge pclk);
        instr.valid <= 1'b0;
        @(posedge pclk);
    endtask : op
    task automatic rise(input logic [23:0] m);
        src_event <= src_event | m[23:1];
        repeat (3) @(posedge pclk);
        src_event <= src_event & ~m[23:1];
        repeat (3) @(posedge pclk);
    endtask : rise
    task automatic ev(input logic [6:0] x);
        for (int i = 0; i < 40 && evq.size() == 0; i++) @(posedge pclk);
        chk((evq.size() == 0) ? 32'h7f : 32'(evq.pop_front()), 32'(x));
    endtask : ev
    task automatic none(input int n);
        repeat (n) @(posedge pclk);
        chk(evq.size(), 0);
    endtask : none
    task automatic done;
        finish <= 1'b1;
        @(posedge pclk);
        finish <= 1'b0;
        @(posedge pclk);
    endtask : done
    task automatic fault(input logic c);
        user_fault       <= 1'b1;
        fault_user_class <= c;
        @(posedge pclk);
        user_fault <= 1'b0;
    endtask : fault

    // -----------------------------------------------------------
    // tests
    // -----------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values and the unmapped error
        apb(0, `USC_CFG_OFF, 0);
        chk(r, 32'h0);
        apb(0, `USC_AUTO_OFF, 0);
        chk(r, 32'h0);
        apb(0, `USC_ENA_OFF, 0);
        chk(r, 32'h00ffffff);
        apb(0, 8'h24, 0);
        chk({e, r[30:0]}, 32'h80000000);
        apb(1, `USC_IMSK_OFF, 32'h2);
        chk(irq, 1'b0);
        // an unconfigured source never dispatches
        rise(24'h8);
        none(12);
        op(usc_op_flush, 24'h8);
        apb(1, `USC_CFG_OFF, 32'hffffff);
        apb(1, `USC_AUTO_OFF, 32'hffffef);
        // without the start setting a request waits for a start
        rise(24'h10);
        none(12);
        apb(1, `USC_START_OFF, 32'h10);
        ev(7'd4);
        apb(0, `USC_START_OFF, 0);
        chk(r, 32'h10);
        done;
        ev(7'h40);
        // a held-off burst runs in fixed order once enabled
        op(usc_op_disable, M);
        rise(M);
        none(12);
        apb(0, `USC_PEND_OFF, 0);
        chk(r, 32'(M));
        op(usc_op_enable, M);
        ev(7'd1);
        done;
        ev(7'd5);
        done;
        ev(7'd11);
        done;
        ev(7'd15);
        done;
        ev(7'd19);
        done;
        ev(7'h40);
        // nesting: higher pre-empts, lower waits for the resume
        rise(24'h800);
        ev(7'd11);
        rise(24'h4);
        ev(7'd2);
        apb(0, `USC_STAT_OFF, 0);
        chk(r, 32'h804);
        rise(24'h100000);
        none(12);
        done;
        ev(7'h2b);
        done;
        ev(7'd20);
        done;
        ev(7'h40);
        // repeat while pending, then clear and flush
        op(usc_op_disable, 24'h80);
        rise(24'h80);
        rise(24'h80);
        apb(0, `USC_LOST_OFF, 0);
        chk(r, 32'h80);
        chk(irq, 1'b1);
        apb(0, `USC_ISTS_OFF, 0);
        chk(32'(r[1]), 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        op(usc_op_clear, 24'h80);
        apb(0, `USC_LOST_OFF, 0);
        chk(r, 32'h0);
        op(usc_op_flush, 24'h80);
        apb(0, `USC_PEND_OFF, 0);
        chk(r, 32'h0);
        op(usc_op_enable, 24'h80);
        none(12);
        // only a user-class fault runs the routine, then fault mode
        fault(1'b0);
        none(12);
        fault(1'b1);
        ev(7'd0);
        chk(fault_mode, 1'b0);
        done;
        none(12);
        chk(fault_mode, 1'b1);
        apb(0, `USC_STAT_OFF, 0);
        chk(32'(r[31]), 32'h1);
        rise(24'h2);
        none(12);
        end_sim;
    end

    // watchdog: the tests need well under 2000 cycles
    initial begin
        #(40 * 20000);
        n_errors++;
        end_sim;
    end
endmodule : user_interrupt_priority_scheduler_bench
